// ==== hw/fcl_ecc_if.sv ====
// Captured ECC fault record and index between the top and the result mux
`timescale 1ns/1ps
interface fcl_ecc_if;
  import fcl_pkg::*;
  fcl_fault_t  rec;
  logic [2:0]  idx;
  logic [15:0] word;
  modport top (output rec, output idx, input word);
  modport mux (input rec, input idx, output word);
endinterface : fcl_ecc_if

// ==== hw/fcl_ecc_mux.sv ====
// ECC result word selection by result index
`timescale 1ns/1ps
module fcl_ecc_mux (
  fcl_ecc_if.mux e
);
  import fcl_pkg::*;
  always_comb begin
    case (e.idx)
      3'h0: e.word = {e.rec.parity, 1'b0, e.rec.addr[22:16]};
      3'h1: e.word = e.rec.addr[15:0];
      3'h2: e.word = e.rec.data[63:48];
      3'h3: e.word = e.rec.pflash ? e.rec.data[47:32] : 16'h0000;
      3'h4: e.word = e.rec.pflash ? e.rec.data[31:16] : 16'h0000;
      3'h5: e.word = e.rec.pflash ? e.rec.data[15:0] : 16'h0000;
      default: e.word = 16'h0000;
    endcase
  end
endmodule : fcl_ecc_mux

// ==== hw/fcl_map.svh ====
// Register offsets, field positions, reset values and timing counts of the flash command block
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH
`define FCL_OFS_CLKDIV      8'h00
`define FCL_OFS_CMDIDX      8'h02
`define FCL_OFS_ECCIDX      8'h04
`define FCL_OFS_STATUS      8'h06
`define FCL_OFS_CMDHI       8'h0a
`define FCL_OFS_CMDLO       8'h0b
`define FCL_OFS_ECCHI       8'h0e
`define FCL_OFS_ECCLO       8'h0f
`define FCL_OFS_OPTION      8'h10
`define FCL_OFS_RSV2        8'h11
`define FCL_OFS_RSV3        8'h12
`define FCL_OFS_RSV4        8'h13
`define FCL_OFS_ECCFLG      8'h14
`define FCL_BIT_DIVLD       7
`define FCL_BIT_CMD_DONE    7
`define FCL_BIT_ACC_ERR     5
`define FCL_BIT_PVIOL       4
`define FCL_BIT_DFDIF       1
`define FCL_BIT_SFDIF       0
`define FCL_RST_CLKDIV      7'h00
`define FCL_RST_OPTION      8'hff
`define FCL_OPT_ADDR        23'h7fff0e
`define FCL_IDX_PARITY_ADDR 3'h0
`define FCL_IDX_ADDR_LO     3'h1
`define FCL_IDX_DATA0       3'h2
`define FCL_IDX_DATA3       3'h5
`define FCL_CLK_MHZ         40
`define FCL_BOOT_NS         100
`define FCL_BOOT_CYC        ((`FCL_BOOT_NS * `FCL_CLK_MHZ + 999) / 1000)
`endif

// ==== hw/fcl_pkg.sv ====
// Types shared by the flash command block
package fcl_pkg;
  typedef enum logic [1:0] {
    FCL_BOOT  = 2'b00,
    FCL_IDLE  = 2'b01,
    FCL_BUSY  = 2'b11
  } fcl_state_t;
  typedef struct packed {
    logic        pflash;
    logic [7:0]  parity;
    logic [22:0] addr;
    logic [63:0] data;
  } fcl_fault_t;
endpackage : fcl_pkg

// ==== hw/fcl_top.sv ====
// Flash command launch, divider gate, option byte and ECC fault reporting with a Wishbone slave
`timescale 1ns/1ps
// Notes on behaviour
// - index 0 gives parity, zero, address high
// - parity holds 8 or 6 bits
// - index 1 gives fault address low half
// - indices 2-5 give raw program phrase
// - data-array fault gives raw word at 2
// - indices 6 and 7 read zero
// - option loaded from nonvolatile byte at reset
// - double fault at load sets option ones
// - option readable, writes ignored
// - reserved test registers read zero
// - divider write sets loaded flag
// - no divider on a program or erase command means access error, no run
// - busy refuses launch and array writes
// - writing one clears flag, hands array
// - controller sets complete flag when done
// - capture frozen until fault flag cleared
// - double fault wins over single fault
`include "fcl_map.svh"
module fcl_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Wishbone slave, 8-bit data
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [0:0]  wb_sel_i,
  input  wire logic [7:0]  wb_dat_i,
  output logic      [7:0]  wb_dat_o,
  output logic             wb_ack_o,
  // Boot read of the nonvolatile option byte
  input  wire logic [7:0]  nonvolatile_option_bits,
  input  wire logic        boot_double_fault,
  // Memory controller command handoff
  output logic             cmd_launch,
  output logic [95:0]      cmd_words,
  output logic             cmd_is_prog_erase,
  input  wire logic        cmd_done,
  input  wire logic        cmd_result_we,
  input  wire logic [95:0] cmd_result,
  // ECC fault capture from array reads
  input  wire logic        ecc_single,
  input  wire logic        ecc_double,
  input  wire fcl_pkg::fcl_fault_t ecc_info,
  // Block state to the memory controller
  output logic [6:0]       divider_value,
  output logic [7:0]       option_byte
);
  import fcl_pkg::*;

  fcl_ecc_if e ();
  fcl_ecc_mux i_fcl_ecc_mux (.e(e));

  fcl_state_t  state_q;
  logic [2:0]  boot_cnt_q;
  logic        divider_loaded_flag_q;
  logic [6:0]  divider_q;
  logic [2:0]  command_index_q;
  logic [2:0]  ecc_result_index_q;
  logic [15:0] cmd_arr_q [6];
  logic        access_error_flag_q;
  logic        pviol_q;
  logic        dfd_q;
  logic        sfd_q;
  fcl_fault_t  rec_q;
  logic [7:0]  option_q;
  logic        ack_q;
  logic [7:0]  dat_q;
  logic        launch_q;
  logic        prog_erase_q;

  logic        acc;
  logic        wr;
  logic        busy;
  logic        launch_req;
  logic        pe_cmd;
  logic [7:0]  rd;
  logic [15:0] cmd_word;

  // One access per ack; ack drops the cycle after it is given
  assign acc  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr   = acc && wb_we_i && wb_sel_i[0];
  assign busy = (state_q == FCL_BUSY);
  assign launch_req = wr && (wb_adr_i == `FCL_OFS_STATUS) && wb_dat_i[`FCL_BIT_CMD_DONE]
                      && state_q == FCL_IDLE;
  // Program and erase commands per command code
  always_comb begin
    case (cmd_arr_q[0][15:8])
      8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h11, 8'h12: pe_cmd = 1'b1;
      default: pe_cmd = 1'b0;
    endcase
  end

  assign e.rec = rec_q;
  assign e.idx = ecc_result_index_q;

  // Boot sequence and command state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q    <= FCL_BOOT;
      boot_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        FCL_BOOT: begin
          boot_cnt_q <= boot_cnt_q + 3'h1;
          if (boot_cnt_q == 3'((`FCL_BOOT_CYC) - 1)) state_q <= FCL_IDLE;
        end
        FCL_IDLE: if (launch_req && !(pe_cmd && !divider_loaded_flag_q)) state_q <= FCL_BUSY;
        FCL_BUSY: if (cmd_done) state_q <= FCL_IDLE;
        default: state_q <= FCL_IDLE;
      endcase
    end
  end

  // Option byte: caught once the boot read completes, never by software
  always_ff @(posedge clock) begin
    if (!rst_b) option_q <= `FCL_RST_OPTION;
    else if (state_q == FCL_BOOT && boot_cnt_q == 3'((`FCL_BOOT_CYC) - 1))
      option_q <= boot_double_fault ? 8'hff : nonvolatile_option_bits;
  end

  // Clock divider and its loaded flag
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      divider_q             <= `FCL_RST_CLKDIV;
      divider_loaded_flag_q <= 1'b0;
    end else if (wr && wb_adr_i == `FCL_OFS_CLKDIV && !busy) begin
      divider_q             <= wb_dat_i[6:0];
      divider_loaded_flag_q <= 1'b1;
    end
  end

  // Index registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      command_index_q    <= 3'h0;
      ecc_result_index_q <= 3'h0;
    end else if (wr && !busy) begin
      if (wb_adr_i == `FCL_OFS_CMDIDX) command_index_q <= wb_dat_i[2:0];
      if (wb_adr_i == `FCL_OFS_ECCIDX) ecc_result_index_q <= wb_dat_i[2:0];
    end
  end

  // Command object array; locked while a command runs
  generate
    for (genvar i = 0; i < 6; i++) begin : g_arr
      always_ff @(posedge clock) begin
        if (!rst_b) cmd_arr_q[i] <= 16'h0000;
        else if (busy && cmd_result_we) cmd_arr_q[i] <= cmd_result[95-16*i -: 16];
        else if (wr && !busy && command_index_q == 3'(i)) begin
          if (wb_adr_i == `FCL_OFS_CMDHI) cmd_arr_q[i][15:8] <= wb_dat_i;
          if (wb_adr_i == `FCL_OFS_CMDLO) cmd_arr_q[i][7:0]  <= wb_dat_i;
        end
      end
    end
  endgenerate

  // Status flags: hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      access_error_flag_q <= 1'b0;
      pviol_q             <= 1'b0;
    end else begin
      if (launch_req && pe_cmd && !divider_loaded_flag_q) access_error_flag_q <= 1'b1;
      else if (wr && wb_adr_i == `FCL_OFS_STATUS && !busy && wb_dat_i[`FCL_BIT_ACC_ERR])
        access_error_flag_q <= 1'b0;
      if (wr && wb_adr_i == `FCL_OFS_STATUS && !busy && wb_dat_i[`FCL_BIT_PVIOL]) pviol_q <= 1'b0;
    end
  end

  // ECC capture, frozen while either fault flag stands
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dfd_q <= 1'b0;
      sfd_q <= 1'b0;
      rec_q <= '0;
    end else if ((ecc_double || ecc_single) && !dfd_q && !sfd_q) begin
      dfd_q <= ecc_double;
      sfd_q <= !ecc_double;
      rec_q <= ecc_info;
      if (!ecc_info.pflash) rec_q.parity[7:6] <= 2'b00;
    end else if (wr && wb_adr_i == `FCL_OFS_ECCFLG) begin
      if (wb_dat_i[`FCL_BIT_DFDIF]) dfd_q <= 1'b0;
      if (wb_dat_i[`FCL_BIT_SFDIF]) sfd_q <= 1'b0;
    end
  end

  assign cmd_word = cmd_arr_q[command_index_q];
  // Read data; unmapped offsets and reserved registers read zero
  always_comb begin
    case (wb_adr_i)
      `FCL_OFS_CLKDIV: rd = {divider_loaded_flag_q, divider_q};
      `FCL_OFS_CMDIDX: rd = {5'h00, command_index_q};
      `FCL_OFS_ECCIDX: rd = {5'h00, ecc_result_index_q};
      `FCL_OFS_STATUS: rd = {!busy, 1'b0, access_error_flag_q, pviol_q, 4'h0};
      `FCL_OFS_CMDHI:  rd = (command_index_q > 3'h5) ? 8'h00 : cmd_word[15:8];
      `FCL_OFS_CMDLO:  rd = (command_index_q > 3'h5) ? 8'h00 : cmd_word[7:0];
      `FCL_OFS_ECCHI:  rd = e.word[15:8];
      `FCL_OFS_ECCLO:  rd = e.word[7:0];
      `FCL_OFS_OPTION: rd = option_q;
      `FCL_OFS_ECCFLG: rd = {6'h00, dfd_q, sfd_q};
      default:         rd = 8'h00;
    endcase
  end

  // Bus answer: one cycle after the request is seen
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else begin
      ack_q <= acc;
      if (acc && !wb_we_i) dat_q <= rd;
    end
  end

  // Command handoff pulse and program or erase flag
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      launch_q     <= 1'b0;
      prog_erase_q <= 1'b0;
    end else begin
      launch_q <= (state_q == FCL_IDLE) && launch_req && !(pe_cmd && !divider_loaded_flag_q);
      if (launch_req) prog_erase_q <= pe_cmd;
    end
  end

  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = dat_q;
  assign cmd_launch        = launch_q;
  assign cmd_is_prog_erase = prog_erase_q;
  assign divider_value     = divider_q;
  assign option_byte       = option_q;
  generate
    for (genvar j = 0; j < 6; j++) begin : g_out
      assign cmd_words[95-16*j -: 16] = cmd_arr_q[j];
    end
  endgenerate
endmodule : fcl_top

// ==== tb/fcl_top_asserts.sv ====
// Port assertions for the flash command block
`timescale 1ns/1ps
module fcl_top_asserts (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // Register bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [0:0] wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic       wb_ack_o,
  // Boot and controller side
  input wire logic [7:0] nonvolatile_option_bits,
  input wire logic       boot_double_fault,
  input wire logic       cmd_launch,
  input wire logic       cmd_is_prog_erase,
  input wire logic       cmd_done,
  input wire logic [6:0] divider_value,
  input wire logic [7:0] option_byte
);
  logic       tw;
  logic       rd;
  logic       div_wr_q;
  logic       busy_q;
  logic [2:0] eidx_q;
  assign tw = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd = wb_ack_o && !wb_we_i;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clock) begin
    if (!rst_b) div_wr_q <= 1'b0;
    else if (tw && wb_adr_i == 8'h00) div_wr_q <= 1'b1;
  end
  // Busy is tracked from the handoff pulses, not from status reads
  always_ff @(posedge clock) begin
    if (!rst_b) busy_q <= 1'b0;
    else if (cmd_launch) busy_q <= 1'b1;
    else if (cmd_done) busy_q <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) eidx_q <= 3'h0;
    else if (tw && wb_adr_i == 8'h04) eidx_q <= wb_dat_i[2:0];
  end
  chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  chk_reserved_zero: assert property (rd && wb_adr_i inside {8'h11, 8'h12, 8'h13} |-> wb_dat_o == 8'h00)
    else $error("reserved register read not zero");
  chk_ecc_unused: assert property (rd && wb_adr_i[7:1] == 7'h07 && eidx_q[2:1] == 2'b11 |-> wb_dat_o == 8'h00)
    else $error("unused result index read not zero");
  chk_option_ro: assert property (tw && wb_adr_i == 8'h10 |=> $stable(option_byte))
    else $error("option byte changed by a write");
  chk_div_load: assert property (tw && wb_adr_i == 8'h00 && !busy_q |-> ##1 divider_value == wb_dat_i[6:0])
    else $error("divider write not taken");
  chk_reset_vals: assert property ($rose(rst_b) |-> divider_value == 7'h00 && option_byte == 8'hff)
    else $error("reset values wrong");
  chk_boot_option: assert property ($rose(rst_b) |-> ##[4:5]
    option_byte == (boot_double_fault ? 8'hff : nonvolatile_option_bits))
    else $error("option byte not loaded at boot");
  chk_pe_gate: assert property (cmd_launch |-> !(cmd_is_prog_erase && !div_wr_q))
    else $error("program or erase launched without divider");
  chk_one_cmd: assert property (cmd_launch |-> !busy_q)
    else $error("launch while a command is active");
  chk_launch_go: assert property (tw && wb_adr_i == 8'h06 && wb_dat_i[7] && !busy_q && div_wr_q |-> ##[1:3] cmd_launch)
    else $error("command not handed over");
endmodule : fcl_top_asserts

// ==== tb/fcl_top_tb_top.sv ====
// Self-checking bench for the flash command block
`timescale 1ns/1ps
module fcl_top_tb_top;
  import fcl_pkg::*;
  logic        clock, rst_b, cyc, stb, we, ack, bdf, launch, pe, done, rwe, es, ed;
  logic [7:0]  adr, dat, rdat, nv;
  logic [95:0] words, res;
  fcl_fault_t  info, fa, fb;
  int          bad_count, checks_done;
  int          launches = 0;
  fcl_top i_fcl_top (.clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(1'b1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .nonvolatile_option_bits(nv), .boot_double_fault(bdf), .cmd_launch(launch), .cmd_words(words),
    .cmd_is_prog_erase(pe), .cmd_done(done), .cmd_result_we(rwe), .cmd_result(res),
    .ecc_single(es), .ecc_double(ed), .ecc_info(info), .divider_value(), .option_byte());
  // Handoff pulses are counted so refused launches can be told from taken ones
  always @(posedge clock) begin
    if (launch === 1'b1) launches <= launches + 1;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input logic [7:0] what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch reg %h expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e}, a);
  endtask : rc
  function automatic logic [15:0] ew(input fcl_fault_t f, input int i);
    logic [7:0] p;
    p = f.pflash ? f.parity : {2'b00, f.parity[5:0]};
    if (i == 0) return {p, 1'b0, f.addr[22:16]};
    if (i == 1) return f.addr[15:0];
    if (i == 2 || (i < 6 && f.pflash)) return f.data[16 * (5 - i) +: 16];
    return 16'h0000;
  endfunction : ew
  task automatic scan(input fcl_fault_t f);
    logic [15:0] e;
    for (int i = 0; i < 8; i++) begin
      e = ew(f, i);
      wr(8'h04, 8'(i));
      rc(8'h0e, e[15:8]);
      rc(8'h0f, e[7:0]);
    end
  endtask : scan
  task automatic fault(input logic s, input logic d, input fcl_fault_t f);
    es   <= s;
    ed   <= d;
    info <= f;
    @(posedge clock);
    es <= 1'b0;
    ed <= 1'b0;
    @(posedge clock);
  endtask : fault
  task automatic boot(input logic df, input logic [7:0] v);
    rst_b <= 1'b0;
    bdf   <= df;
    nv    <= v;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : boot
  initial begin
    clock = 1'b0;
    // 40 MHz bus clock, well above the lowest rate that program and erase tolerate
    forever #12.5 clock = ~clock;
  end
  initial begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 8'h00;
    bdf = 1'b0;
    nv = 8'h00;
    done = 1'b0;
    rwe = 1'b0;
    res = '0;
    es = 1'b0;
    ed = 1'b0;
    info = '0;
    bad_count = 0;
    checks_done = 0;
    boot(1'b0, 8'h5a);
    rc(8'h00, 8'h00);
    rc(8'h10, 8'h5a);
    wr(8'h10, 8'h00);
    rc(8'h10, 8'h5a);
    for (int a = 8'h11; a < 8'h14; a++) begin
      wr(8'(a), 8'hff);
      rc(8'(a), 8'h00);
    end
    rc(8'h30, 8'h00);
    $display("register test done");
    wr(8'h02, 8'h00);
    wr(8'h0a, 8'h06);
    wr(8'h0b, 8'h00);
    wr(8'h06, 8'h80);
    rc(8'h06, 8'ha0);
    chk(16'(launches), 16'h0000, 8'h06);
    wr(8'h06, 8'h20);
    rc(8'h06, 8'h80);
    wr(8'h00, 8'h27);
    rc(8'h00, 8'ha7);
    wr(8'h06, 8'h80);
    rc(8'h06, 8'h00);
    chk(words[95:80], 16'h0600, 8'h0a);
    chk(16'(launches), 16'h0001, 8'h06);
    chk({15'h0000, pe}, 16'h0001, 8'h06);
    wr(8'h0a, 8'h33);
    wr(8'h06, 8'h80);
    rc(8'h0a, 8'h06);
    chk(16'(launches), 16'h0001, 8'h06);
    res <= {16'hbeef, 80'h0};
    rwe <= 1'b1;
    @(posedge clock);
    rwe  <= 1'b0;
    done <= 1'b1;
    @(posedge clock);
    done <= 1'b0;
    rc(8'h06, 8'h80);
    rc(8'h0a, 8'hbe);
    $display("command test done");
    fa = '{1'b1, 8'hc3, 23'h7a1234, 64'h1111_2222_3333_4444};
    fault(1'b0, 1'b1, fa);
    scan(fa);
    fault(1'b1, 1'b0, '{1'b0, 8'h11, 23'h0, 64'h0});
    wr(8'h04, 8'h01);
    rc(8'h0f, 8'h34);
    rc(8'h14, 8'h02);
    wr(8'h14, 8'h03);
    fb = '{1'b0, 8'hff, 23'h100040, 64'habcd_0000_5555_6666};
    fault(1'b1, 1'b1, fb);
    rc(8'h14, 8'h02);
    scan(fb);
    $display("ecc test done");
    boot(1'b1, 8'h3c);
    rc(8'h10, 8'hff);
    rc(8'h00, 8'h00);
    boot(1'b0, 8'h96);
    rc(8'h10, 8'h96);
    $display("boot fault test done");
    wrap_up();
  end
endmodule : fcl_top_tb_top
bind fcl_top fcl_top_asserts i_fcl_top_asserts (.clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .nonvolatile_option_bits, .boot_double_fault, .cmd_launch,
  .cmd_is_prog_erase, .cmd_done, .divider_value, .option_byte);
